// ---- csc_regs.svh ----
// constants for the charger state and status control block
// assumes a 25 MHz system clock; included by its bare name
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH
`define CSC_CLK_HZ 25000000
`define CSC_TERM_FILTER_US 1000
`define CSC_TERM_FILTER_CYC ((`CSC_TERM_FILTER_US * (`CSC_CLK_HZ / 1000000)))
`define CSC_SAFETY_TIMER_CYC 32'h0001_0000
`define CSC_ILIM_USB_LO_MA 12'h064
`define CSC_ILIM_USB_HI_MA 12'h1f4
`define CSC_ILIM_ADAPTER_MA 12'h708
`define CSC_PRECOND_DIV 4'ha
`define CSC_SYNC_RESET 1'b0
`endif

// ---- csc_pkg.sv ----
// types shared by the charger state and status control block
// no dependencies
package csc_pkg;
    typedef enum logic [3:0] {
        ST_SHUTDOWN,
        ST_PRECOND,
        ST_CC,
        ST_CV,
        ST_COMPLETE,
        ST_TEMP_FAULT,
        ST_TIMER_FAULT,
        ST_NO_BATT
    } csc_state_t;

    typedef struct packed {
        logic inputAboveUvlo;
        logic inputAboveBatt;
        logic battPresent;
        logic battAbovePrecond;
        logic battAtReg;
        logic battBelowRecharge;
        logic battLow;
        logic thermInWindow;
        logic termCurrentLow;
    } csc_sense_t;

    typedef struct packed {
        logic sourceSelect;
        logic usbLimitSelect;
        logic timerEnableN;
        logic chargeEnable;
    } csc_select_t;

    typedef struct packed {
        logic passOn;
        logic precondCurrent;
        logic cvMode;
        logic battToSystem;
        logic [11:0] inputLimitMa;
    } csc_power_t;
endpackage

// ---- csc_sync.sv ----
// two-flop synchroniser for a group of level signals
// assumes the inputs change slowly relative to the clock
`timescale 1ns/10ps
module csc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

// ---- csc_charger_ctrl.sv ----
// charge-cycle state machine with open-drain status and power-good outputs
// assumes comparator flags and selects come from outside, any timing
`timescale 1ns/10ps
`include "csc_regs.svh"
// Functional notes
// - status and power-good pins only pull low or float, never drive high
// - charging: a low; complete: b low; temperature or timer fault: both low
// - low battery with no input: a only; no battery or shutdown: both float; other no input: all float
// - power-good only sinks current; external pull-up sets released level
// - power-good low while input above lockout and above battery voltage
// - source select low: USB mode, input limit per usb limit select
// - source select high: limit input to 1.8 A, full programmed charge current
// - safety timer runs only while timer enable input is low
// - thermistor window checked only during an active charge cycle
// - thermistor outside window in charge: suspend at once, temperature fault
// - temperature suspend turns pass device off and freezes timer count
// - thermistor back in window: resume held state with held timer
// - preconditioning commands one tenth of fast charge current
// - without input supply the battery feeds the system load
// - constant current always precedes constant voltage within a cycle
// - leave preconditioning above threshold; entering constant current resets timer, except on resume from temperature fault
// - timer expiry in fast charge: timer fault until battery removed, then standby
// - charge complete only after termination flag holds 1 ms continuously
// - in charge complete, recharge starts when battery falls below threshold
module csc_charger_ctrl #(
    parameter int TERM_FILTER_CYC = `CSC_TERM_FILTER_CYC,
    parameter int SAFETY_TIMER_CYC = `CSC_SAFETY_TIMER_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire csc_pkg::csc_sense_t senseIn,
    input wire csc_pkg::csc_select_t selectIn,
    input wire logic chargeStateAIn,
    output logic chargeStateAOut,
    output logic chargeStateAOe,
    input wire logic chargeStateBIn,
    output logic chargeStateBOut,
    output logic chargeStateBOe,
    input wire logic inputPowerGoodNIn,
    output logic inputPowerGoodNOut,
    output logic inputPowerGoodNOe,
    output csc_pkg::csc_power_t powerCtrl,
    output csc_pkg::csc_state_t chargeState,
    output logic [3:0] precondDivisor
);
    localparam int SW = $bits(csc_pkg::csc_sense_t) + $bits(csc_pkg::csc_select_t);

    csc_pkg::csc_sense_t sense;
    csc_pkg::csc_select_t sel;
    csc_pkg::csc_state_t state_q;
    csc_pkg::csc_state_t state_d;
    csc_pkg::csc_state_t held_q;
    logic [31:0] timer_q;
    logic [31:0] filter_q;
    logic timerExpired;
    logic termHeld;
    logic inputOk;
    logic charging;
    logic outA;
    logic outB;
    logic outPg;
    logic passOn_q;
    logic precondCurrent_q;
    logic cvMode_q;
    logic battToSystem_q;
    logic [11:0] inputLimit_q;

    // bring comparator flags and selects onto the clock
    csc_sync #(
        .WIDTH(SW)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn({senseIn, selectIn}),
        .syncOut({sense, sel})
    );

    // true in states where current flows into the cell
    function automatic logic is_charging(input csc_pkg::csc_state_t s);
        return (s == csc_pkg::ST_PRECOND) || (s == csc_pkg::ST_CC) || (s == csc_pkg::ST_CV);
    endfunction

    assign inputOk = sense.inputAboveUvlo && sense.inputAboveBatt;
    assign charging = is_charging(state_q);
    assign timerExpired = (timer_q >= 32'(SAFETY_TIMER_CYC));
    assign termHeld = (filter_q >= 32'(TERM_FILTER_CYC));

    // next-state logic of the charge cycle
    always_comb begin
        state_d = state_q;
        case (state_q)
            csc_pkg::ST_SHUTDOWN: begin
                if (inputOk && sel.chargeEnable) begin
                    if (!sense.battPresent) begin
                        state_d = csc_pkg::ST_NO_BATT;
                    end else if (sense.battAbovePrecond) begin
                        state_d = csc_pkg::ST_CC;
                    end else begin
                        state_d = csc_pkg::ST_PRECOND;
                    end
                end
            end
            csc_pkg::ST_PRECOND: begin
                if (sense.battAbovePrecond) begin
                    state_d = csc_pkg::ST_CC;
                end
            end
            csc_pkg::ST_CC: begin
                if (sel.timerEnableN == 1'b0 && timerExpired) begin
                    state_d = csc_pkg::ST_TIMER_FAULT;
                end else if (sense.battAtReg) begin
                    state_d = csc_pkg::ST_CV;
                end
            end
            csc_pkg::ST_CV: begin
                if (sel.timerEnableN == 1'b0 && timerExpired) begin
                    state_d = csc_pkg::ST_TIMER_FAULT;
                end else if (termHeld) begin
                    state_d = csc_pkg::ST_COMPLETE;
                end
            end
            csc_pkg::ST_COMPLETE: begin
                if (!sense.battPresent) begin
                    state_d = csc_pkg::ST_NO_BATT;
                end else if (sense.battBelowRecharge) begin
                    state_d = sense.battAbovePrecond ? csc_pkg::ST_CC : csc_pkg::ST_PRECOND;
                end
            end
            csc_pkg::ST_TEMP_FAULT: begin
                if (sense.thermInWindow) begin
                    state_d = held_q;
                end
            end
            csc_pkg::ST_TIMER_FAULT: begin
                if (!sense.battPresent) begin
                    state_d = csc_pkg::ST_NO_BATT;
                end
            end
            csc_pkg::ST_NO_BATT: begin
                if (sense.battPresent) begin
                    state_d = csc_pkg::ST_SHUTDOWN;
                end
            end
            default: begin
                state_d = csc_pkg::ST_SHUTDOWN;
            end
        endcase
        // thermistor checked only while charging
        if (charging && !sense.thermInWindow) begin
            state_d = csc_pkg::ST_TEMP_FAULT;
        end
        // a missing cell ends any charge or fault
        if (state_q != csc_pkg::ST_SHUTDOWN && state_q != csc_pkg::ST_NO_BATT
                && !sense.battPresent) begin
            state_d = csc_pkg::ST_NO_BATT;
        end
        // loss of input or disable overrides everything
        if (!inputOk || !sel.chargeEnable) begin
            state_d = csc_pkg::ST_SHUTDOWN;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= csc_pkg::ST_SHUTDOWN;
        end else begin
            state_q <= state_d;
        end
    end

    // remember the charge phase that a temperature fault interrupted
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            held_q <= csc_pkg::ST_PRECOND;
        end else if (charging && state_d == csc_pkg::ST_TEMP_FAULT) begin
            held_q <= state_q;
        end
    end

    // safety timer: cleared on entry to constant current except from temperature fault, frozen in faults
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            timer_q <= '0;
        end else if (state_d == csc_pkg::ST_CC && state_q != csc_pkg::ST_CC
                && state_q != csc_pkg::ST_TEMP_FAULT) begin
            timer_q <= '0;
        end else if (state_q == csc_pkg::ST_TEMP_FAULT) begin
            timer_q <= timer_q;
        end else if ((state_q == csc_pkg::ST_CC || state_q == csc_pkg::ST_CV)
                && sel.timerEnableN == 1'b0 && !timerExpired) begin
            timer_q <= timer_q + 32'h1;
        end
    end

    // termination filter: any gap in the flag restarts the count
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            filter_q <= '0;
        end else if (state_q != csc_pkg::ST_CV || !sense.termCurrentLow) begin
            filter_q <= '0;
        end else if (!termHeld) begin
            filter_q <= filter_q + 32'h1;
        end
    end

    // status pin levels; 1 means pull low
    always_comb begin
        outA = 1'b0;
        outB = 1'b0;
        case (state_q)
            csc_pkg::ST_PRECOND, csc_pkg::ST_CC, csc_pkg::ST_CV: begin
                outA = 1'b1;
            end
            csc_pkg::ST_COMPLETE: begin
                outB = 1'b1;
            end
            csc_pkg::ST_TEMP_FAULT, csc_pkg::ST_TIMER_FAULT: begin
                outA = 1'b1;
                outB = 1'b1;
            end
            default: begin
                outA = 1'b0;
                outB = 1'b0;
            end
        endcase
        if (sense.battLow && !inputOk) begin
            outA = 1'b1;
            outB = 1'b0;
        end
        outPg = inputOk;
    end

    // open-drain drivers: data always low, enable carries the level
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            chargeStateAOe <= 1'b0;
            chargeStateBOe <= 1'b0;
            inputPowerGoodNOe <= 1'b0;
        end else begin
            chargeStateAOe <= outA;
            chargeStateBOe <= outB;
            inputPowerGoodNOe <= outPg;
        end
    end
    assign chargeStateAOut = 1'b0;
    assign chargeStateBOut = 1'b0;
    assign inputPowerGoodNOut = 1'b0;

    // input current budget chosen by the source and usb limit selects
    function automatic logic [11:0] input_limit(input csc_pkg::csc_select_t s);
        if (s.sourceSelect) begin
            return `CSC_ILIM_ADAPTER_MA;
        end else if (s.usbLimitSelect) begin
            return `CSC_ILIM_USB_HI_MA;
        end
        return `CSC_ILIM_USB_LO_MA;
    endfunction

    // charge-path commands follow the registered state
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            passOn_q <= 1'b0;
            precondCurrent_q <= 1'b0;
            cvMode_q <= 1'b0;
        end else begin
            passOn_q <= is_charging(state_q);
            precondCurrent_q <= (state_q == csc_pkg::ST_PRECOND);
            cvMode_q <= (state_q == csc_pkg::ST_CV);
        end
    end

    // battery carries the system load whenever the input is not usable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            battToSystem_q <= 1'b1;
        end else begin
            battToSystem_q <= !inputOk;
        end
    end

    // input current limit follows the synchronised selects
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            inputLimit_q <= 12'h000;
        end else begin
            inputLimit_q <= input_limit(sel);
        end
    end

    // power-path commands to the analog section, all from flip-flops
    assign powerCtrl = {passOn_q, precondCurrent_q, cvMode_q, battToSystem_q, inputLimit_q};

    assign chargeState = state_q;
    assign precondDivisor = `CSC_PRECOND_DIV;

    // pin readback is not needed by the control logic
    logic unusedPins;
    assign unusedPins = chargeStateAIn ^ chargeStateBIn ^ inputPowerGoodNIn;
endmodule

// ---- csc_charger_ctrl_asserts.sv ----
// assertions for the charger state and status control block
// bound to csc_charger_ctrl; sees only its ports
`timescale 1ns/10ps
`include "csc_regs.svh"
module csc_charger_ctrl_asserts #(
    parameter int TERM_FILTER_CYC = `CSC_TERM_FILTER_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire csc_pkg::csc_sense_t senseIn,
    input wire csc_pkg::csc_select_t selectIn,
    input wire logic chargeStateAOut,
    input wire logic chargeStateAOe,
    input wire logic chargeStateBOut,
    input wire logic chargeStateBOe,
    input wire logic inputPowerGoodNOut,
    input wire logic inputPowerGoodNOe,
    input wire csc_pkg::csc_power_t powerCtrl,
    input wire csc_pkg::csc_state_t chargeState,
    input wire logic [3:0] precondDivisor
);
    logic chg;
    logic pgIn;
    logic [11:0] limExp;
    int termRun_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // charging states, power-good cause and the limit the selects ask for
    assign chg = chargeState inside {csc_pkg::ST_PRECOND, csc_pkg::ST_CC, csc_pkg::ST_CV};
    assign pgIn = senseIn.inputAboveUvlo && senseIn.inputAboveBatt;
    assign limExp = selectIn.sourceSelect ? `CSC_ILIM_ADAPTER_MA :
        (selectIn.usbLimitSelect ? `CSC_ILIM_USB_HI_MA : `CSC_ILIM_USB_LO_MA);
    // length of the current unbroken run of the termination flag
    always_ff @(posedge clk) begin
        if (!rst_b || !senseIn.termCurrentLow) termRun_q <= 0;
        else termRun_q <= termRun_q + 1;
    end
    a_pins_low_only:
        assert property (!chargeStateAOut && !chargeStateBOut && !inputPowerGoodNOut)
        else $error("status pin data not low");
    a_reset_clear:
        assert property (disable iff (1'b0) !rst_b |=> !chargeStateAOe && !chargeStateBOe
            && !inputPowerGoodNOe && chargeState == csc_pkg::ST_SHUTDOWN)
        else $error("reset did not release outputs");
    a_charging_pins:
        assert property (chg |=> chargeStateAOe && !chargeStateBOe)
        else $error("charging pin pattern wrong");
    a_complete_pins:
        assert property (chargeState == csc_pkg::ST_COMPLETE && $past(pgIn, 2)
            |=> !chargeStateAOe && chargeStateBOe)
        else $error("complete pin pattern wrong");
    a_fault_pins:
        assert property (chargeState inside {csc_pkg::ST_TEMP_FAULT, csc_pkg::ST_TIMER_FAULT}
            && $past(pgIn, 2) |=> chargeStateAOe && chargeStateBOe)
        else $error("fault pin pattern wrong");
    a_idle_pins:
        assert property (chargeState inside {csc_pkg::ST_SHUTDOWN, csc_pkg::ST_NO_BATT}
            |=> !chargeStateBOe)
        else $error("idle state pulls second pin");
    a_power_good:
        assert property ($stable(pgIn)[*5] |-> inputPowerGoodNOe == pgIn)
        else $error("power-good does not follow input");
    a_input_limit:
        assert property ($stable(selectIn)[*5] ##0 chg |-> powerCtrl.inputLimitMa == limExp)
        else $error("input limit wrong");
    a_thermistor_sense_suspend:
        assert property (chg && !senseIn.thermInWindow |-> ##[1:4] chargeState inside
            {csc_pkg::ST_TEMP_FAULT, csc_pkg::ST_SHUTDOWN, csc_pkg::ST_NO_BATT})
        else $error("thermistor fault not taken");
    a_temp_pass_off:
        assert property (chargeState == csc_pkg::ST_TEMP_FAULT |=> !powerCtrl.passOn)
        else $error("pass device on in temperature fault");
    a_precond_tenth:
        assert property (chargeState == csc_pkg::ST_PRECOND |=>
            powerCtrl.precondCurrent && precondDivisor == 4'ha)
        else $error("precondition current not a tenth");
    a_cc_before_cv:
        assert property (chargeState == csc_pkg::ST_CV && $past(chargeState) != csc_pkg::ST_CV
            |-> $past(chargeState) inside {csc_pkg::ST_CC, csc_pkg::ST_TEMP_FAULT})
        else $error("voltage mode entered without current mode");
    a_term_filter:
        assert property (chargeState == csc_pkg::ST_COMPLETE
            && $past(chargeState) == csc_pkg::ST_CV |-> termRun_q >= TERM_FILTER_CYC)
        else $error("complete entered before filter time");
    a_batt_feeds:
        assert property ((!senseIn.inputAboveUvlo)[*5] |-> powerCtrl.battToSystem)
        else $error("battery not feeding system");
    c_complete: cover property (chargeState == csc_pkg::ST_COMPLETE);
    c_temp: cover property (chargeState == csc_pkg::ST_TEMP_FAULT);
    c_timer: cover property (chargeState == csc_pkg::ST_TIMER_FAULT);
endmodule
bind csc_charger_ctrl csc_charger_ctrl_asserts #(.TERM_FILTER_CYC(TERM_FILTER_CYC)) u_chk (
    .clk(clk), .rst_b(rst_b), .senseIn(senseIn), .selectIn(selectIn),
    .chargeStateAOut(chargeStateAOut), .chargeStateAOe(chargeStateAOe),
    .chargeStateBOut(chargeStateBOut), .chargeStateBOe(chargeStateBOe),
    .inputPowerGoodNOut(inputPowerGoodNOut), .inputPowerGoodNOe(inputPowerGoodNOe),
    .powerCtrl(powerCtrl), .chargeState(chargeState), .precondDivisor(precondDivisor));

// ---- csc_host_model.sv ----
// host side: pull-ups on the status pins and the select drivers
// assumes enables from the charger that are high while pulling low
`timescale 1ns/10ps
module csc_host_model (
    input wire csc_pkg::csc_select_t selCmd,
    input wire logic aOut,
    input wire logic aOe,
    input wire logic bOut,
    input wire logic bOe,
    input wire logic pgOut,
    input wire logic pgOe,
    output csc_pkg::csc_select_t selOut,
    output logic pinA,
    output logic pinB,
    output logic pinPg
);
    // pull-ups give the released level; an enable pulls the wire low
    assign pinA = aOe ? aOut : 1'b1;
    assign pinB = bOe ? bOut : 1'b1;
    assign pinPg = pgOe ? pgOut : 1'b1;
    // host drives the select levels, limit select low for the small budget
    assign selOut = selCmd;
endmodule

// ---- csc_tb.sv ----
// self-checking bench for the charger state and status control block
// assumes the host model resolves the open-drain pins with pull-ups
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    csc_pkg::csc_sense_t sense = 9'h000;
    csc_pkg::csc_select_t selCmd = 4'h3;
    csc_pkg::csc_select_t selectIn;
    csc_pkg::csc_power_t powerCtrl;
    csc_pkg::csc_state_t chargeState;
    logic aOe, bOe, pgOe, pinA, pinB, pinPg;
    logic aOut, bOut, pgOut;
    logic [3:0] precondDivisor;
    logic [11:0] lims [3] = '{12'h064, 12'h1f4, 12'h708};
    int fails = 0;
    int n_checks = 0;
    // 25 MHz clock
    always #20 clk = !clk;
    csc_charger_ctrl #(.TERM_FILTER_CYC(20), .SAFETY_TIMER_CYC(50)) uut (
        .clk(clk), .rst_b(rst_b), .senseIn(sense), .selectIn(selectIn),
        .chargeStateAIn(pinA), .chargeStateAOut(aOut), .chargeStateAOe(aOe),
        .chargeStateBIn(pinB), .chargeStateBOut(bOut), .chargeStateBOe(bOe),
        .inputPowerGoodNIn(pinPg), .inputPowerGoodNOut(pgOut), .inputPowerGoodNOe(pgOe),
        .powerCtrl(powerCtrl), .chargeState(chargeState), .precondDivisor(precondDivisor));
    csc_host_model host (.selCmd(selCmd), .aOut(aOut), .aOe(aOe), .bOut(bOut), .bOe(bOe),
        .pgOut(pgOut), .pgOe(pgOe),
        .selOut(selectIn), .pinA(pinA), .pinB(pinB), .pinPg(pinPg));
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // drives land on the rising edge; reads there see the values settled before it
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    // wait a bounded time for a state, then compare it and the pins a, b, pg
    task automatic expect_st(csc_pkg::csc_state_t st, logic [2:0] pins, int lim = 8);
        for (int i = 0; i < lim && chargeState !== st; i++) tick(1);
        tick(1);
        check("state", 16'(chargeState), 16'(st));
        check("pins", 16'({pinA, pinB, pinPg}), 16'(pins));
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // tests take well under 1000 cycles; cut a hang after 5000
    initial begin
        #200000;
        fails++;
        test_done();
    end
    initial begin
        tick(6);
        rst_b <= 1'b1;
        expect_st(csc_pkg::ST_SHUTDOWN, 3'b111);
        $display("test reset done");
        // powered and enabled, deep battery, thermistor in window
        sense <= 9'h1c2;
        expect_st(csc_pkg::ST_PRECOND, 3'b010);
        check("precond", 16'({powerCtrl.precondCurrent, precondDivisor}), 16'h001a);
        for (int i = 0; i < 3; i++) begin
            selCmd.sourceSelect <= i[1];
            selCmd.usbLimitSelect <= i[0];
            tick(6);
            check("limit", 16'(powerCtrl.inputLimitMa), 16'(lims[i]));
        end
        $display("test precondition done");
        sense.battAbovePrecond <= 1'b1;
        expect_st(csc_pkg::ST_CC, 3'b010);
        tick(80);
        check("timer off", 16'(chargeState), 16'(csc_pkg::ST_CC));
        sense.thermInWindow <= 1'b0;
        expect_st(csc_pkg::ST_TEMP_FAULT, 3'b000);
        check("pass", 16'(powerCtrl.passOn), 16'h0000);
        sense.thermInWindow <= 1'b1;
        expect_st(csc_pkg::ST_CC, 3'b010);
        $display("test temperature done");
        sense.battAtReg <= 1'b1;
        expect_st(csc_pkg::ST_CV, 3'b010);
        check("cv mode", 16'(powerCtrl.cvMode), 16'h0001);
        sense.termCurrentLow <= 1'b1;
        tick(10);
        sense.termCurrentLow <= 1'b0;
        tick(30);
        check("short term", 16'(chargeState), 16'(csc_pkg::ST_CV));
        sense.termCurrentLow <= 1'b1;
        expect_st(csc_pkg::ST_COMPLETE, 3'b100, 40);
        sense.battAtReg <= 1'b0;
        sense.termCurrentLow <= 1'b0;
        sense.battBelowRecharge <= 1'b1;
        expect_st(csc_pkg::ST_CC, 3'b010);
        sense.battBelowRecharge <= 1'b0;
        $display("test termination done");
        selCmd.timerEnableN <= 1'b0;
        tick(20);
        sense.thermInWindow <= 1'b0;
        expect_st(csc_pkg::ST_TEMP_FAULT, 3'b000);
        tick(80);
        check("temp held", 16'(chargeState), 16'(csc_pkg::ST_TEMP_FAULT));
        sense.thermInWindow <= 1'b1;
        expect_st(csc_pkg::ST_CC, 3'b010);
        check("pass on", 16'(powerCtrl.passOn), 16'h0001);
        expect_st(csc_pkg::ST_TIMER_FAULT, 3'b000, 40);
        sense.battPresent <= 1'b0;
        expect_st(csc_pkg::ST_NO_BATT, 3'b110);
        sense.thermInWindow <= 1'b0;
        tick(10);
        check("thermistor_sense idle", 16'(chargeState), 16'(csc_pkg::ST_NO_BATT));
        $display("test timer done");
        selCmd.chargeEnable <= 1'b0;
        sense.battPresent <= 1'b1;
        expect_st(csc_pkg::ST_SHUTDOWN, 3'b110);
        sense <= 9'h024;
        selCmd.chargeEnable <= 1'b1;
        tick(8);
        expect_st(csc_pkg::ST_SHUTDOWN, 3'b011);
        check("batt feeds", 16'(powerCtrl.battToSystem), 16'h0001);
        $display("test shutdown done");
        test_done();
    end
endmodule
